//--- dmwp_top.sv
// host controller driving the dual microstep write port over its pins.
// assumes an AXI4-Lite master on the same clock; device pins are async.
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - The host drives an eight-bit word on the data lines during every write.
// - Channel select low writes channel 1 and high writes channel 2.
// - Register select low writes the level register and high the threshold register.
// - Chip select is held low around every write strobe and high otherwise.
module dmwp_top #(
	parameter int STROBE_CYC = dmwp_pkg::STROBE_CYC,
	parameter int RESET_CYC = dmwp_pkg::RESET_CYC
) (
	// clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// AXI4-Lite write
	input wire logic [3:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read
	input wire logic [3:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// device write port
	output logic [7:0] DATA_OUT,
	output logic CHANNEL_SELECT,
	output logic THRESHOLD_REGISTER_SELECT,
	output logic CS_N,
	output logic WR_N,
	output logic DEVICE_RESET,
	// device outputs read back
	input wire logic DIRECTION_OUT_CH1,
	input wire logic DIRECTION_OUT_CH2,
	input wire logic FAST_DECAY_N_CH1,
	input wire logic FAST_DECAY_N_CH2
);
	localparam int LW = dmwp_pkg::LVL_W;
	localparam int TW = dmwp_pkg::THR_W;

	function automatic logic [2:0] thr_field(input logic [7:0] d);
		return d[dmwp_pkg::THR_LSB +: TW];
	endfunction

	// ============================================================
	// pin sequencer
	logic seq_start, seq_reset_req, seq_busy, seq_commit;
	logic [7:0] seq_data;
	logic seq_chan, seq_thr;

	dmwp_seq #(.STROBE_CYC(STROBE_CYC), .RESET_CYC(RESET_CYC)) u_seq (
		.clk(CLK),
		.rst(SYS_RST),
		.start(seq_start),
		.start_data(seq_data),
		.start_chan(seq_chan),
		.start_thr(seq_thr),
		.reset_req(seq_reset_req),
		.data_out(DATA_OUT),
		.chan_sel(CHANNEL_SELECT),
		.thr_sel(THRESHOLD_REGISTER_SELECT),
		.cs_n(CS_N),
		.wr_n(WR_N),
		.dev_reset(DEVICE_RESET),
		.busy(seq_busy),
		.commit(seq_commit)
	);

	// ============================================================
	// device readback synchroniser
	// fast-decay and direction come from the device's own logic
	logic [3:0] pin_meta, pin_sync;

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pin_meta <= 4'h0;
			pin_sync <= 4'h0;
		end else begin
			pin_meta <= {FAST_DECAY_N_CH2, FAST_DECAY_N_CH1,
				DIRECTION_OUT_CH2, DIRECTION_OUT_CH1};
			pin_sync <= pin_meta;
		end
	end

	// ============================================================
	// mirror of what the device holds, per channel
	logic [LW-1:0] mir_lvl [2];
	logic [LW-1:0] next_mir_lvl [2];
	logic [1:0] mir_dir, next_mir_dir;
	logic [TW-1:0] mir_thr [2];
	logic [TW-1:0] next_mir_thr [2];

	always_comb begin
		next_mir_lvl = mir_lvl;
		next_mir_dir = mir_dir;
		next_mir_thr = mir_thr;
		if (DEVICE_RESET) begin
			// device cleared, so is the copy
			next_mir_lvl = '{default: '0};
			next_mir_dir = 2'b00;
			next_mir_thr = '{default: '0};
		end else if (seq_commit && !THRESHOLD_REGISTER_SELECT) begin
			next_mir_lvl[CHANNEL_SELECT] = DATA_OUT[LW-1:0];
			next_mir_dir[CHANNEL_SELECT] = DATA_OUT[dmwp_pkg::DIR_BIT];
		end else if (seq_commit) begin
			next_mir_thr[CHANNEL_SELECT] = thr_field(DATA_OUT);
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			mir_lvl <= '{default: '0};
			mir_dir <= 2'b00;
			mir_thr <= '{default: '0};
		end else begin
			mir_lvl <= next_mir_lvl;
			mir_dir <= next_mir_dir;
			mir_thr <= next_mir_thr;
		end
	end

	// ============================================================
	// AXI4-Lite slave, one write and one read at a time
	logic aw_held, next_aw_held, w_held, next_w_held;
	logic [3:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;

	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = S_AXI_BVALID;
		next_bresp = S_AXI_BRESP;
		next_rvalid = S_AXI_RVALID;
		next_rresp = S_AXI_RRESP;
		next_rdata = S_AXI_RDATA;
		seq_start = 1'b0;
		seq_reset_req = 1'b0;
		seq_data = w_data[7:0];
		seq_chan = w_data[dmwp_pkg::CMD_CHAN_BIT];
		seq_thr = w_data[dmwp_pkg::CMD_THR_BIT];
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			next_aw_held = 1'b1;
			next_aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			next_w_held = 1'b1;
			next_w_data = S_AXI_WDATA;
			next_w_strb = S_AXI_WSTRB;
		end
		if (S_AXI_BVALID && S_AXI_BREADY) begin
			next_bvalid = 1'b0;
		end
		if (aw_held && w_held && !S_AXI_BVALID) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = dmwp_pkg::RESP_OKAY;
			unique case (aw_addr)
				dmwp_pkg::REG_CMD: begin
					// a busy port refuses rather than queues
					if (seq_busy) begin
						next_bresp = dmwp_pkg::RESP_SLVERR;
					end else begin
						seq_start = &w_strb[1:0];
					end
				end
				dmwp_pkg::REG_CTRL: begin
					seq_reset_req = w_strb[0] &&
						w_data[dmwp_pkg::CTRL_RESET_BIT];
				end
				dmwp_pkg::REG_STATUS, dmwp_pkg::REG_MIRROR: begin
					next_bresp = dmwp_pkg::RESP_OKAY;
				end
				default: next_bresp = dmwp_pkg::RESP_DECERR;
			endcase
		end
		if (S_AXI_RVALID && S_AXI_RREADY) begin
			next_rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			next_rvalid = 1'b1;
			next_rresp = dmwp_pkg::RESP_OKAY;
			next_rdata = 32'h0000_0000;
			unique case (S_AXI_ARADDR)
				dmwp_pkg::REG_CMD, dmwp_pkg::REG_CTRL: begin
					next_rdata = 32'h0000_0000;
				end
				dmwp_pkg::REG_STATUS: begin
					// fast-decay bits read low for fast decay
					next_rdata[5:0] = {pin_sync, DEVICE_RESET, seq_busy};
				end
				dmwp_pkg::REG_MIRROR: begin
					next_rdata[LW:0] = {mir_dir[0], mir_lvl[0]};
					next_rdata[dmwp_pkg::MIR_THR_OFS +: TW] = mir_thr[0];
					next_rdata[dmwp_pkg::MIR_CH2_LSB +: LW+1] =
						{mir_dir[1], mir_lvl[1]};
					next_rdata[dmwp_pkg::MIR_CH2_LSB +
						dmwp_pkg::MIR_THR_OFS +: TW] = mir_thr[1];
				end
				default: next_rresp = dmwp_pkg::RESP_DECERR;
			endcase
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= 2'h0;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RRESP <= 2'h0;
			S_AXI_RDATA <= 32'h0000_0000;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			S_AXI_AWREADY <= next_awready;
			S_AXI_WREADY <= next_wready;
			S_AXI_BVALID <= next_bvalid;
			S_AXI_BRESP <= next_bresp;
			S_AXI_ARREADY <= next_arready;
			S_AXI_RVALID <= next_rvalid;
			S_AXI_RRESP <= next_rresp;
			S_AXI_RDATA <= next_rdata;
		end
	end

	// ============================================================
	// checks
	a_mirror_dir: assert property (@(posedge CLK) disable iff (SYS_RST)
		seq_commit && !THRESHOLD_REGISTER_SELECT && !DEVICE_RESET |=>
		mir_dir[$past(CHANNEL_SELECT)] == $past(DATA_OUT[7]))
		else $error("direction copy not taken from bit 7");
	a_mirror_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
		DEVICE_RESET |=> mir_dir == 2'b00 && mir_lvl[0] == '0 &&
		mir_lvl[1] == '0) else $error("copy not cleared by reset");
	a_busy_refuse: assert property (@(posedge CLK) disable iff (SYS_RST)
		seq_start |-> !seq_busy && !DEVICE_RESET)
		else $error("write launched while busy");
endmodule
`default_nettype wire

//--- dmwp_seq.sv
// package of shared constants and the pin write sequencer.
// assumes one 250 MHz clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// shared constants
package dmwp_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam int T_CS_SETUP_NS = 80;
	localparam int T_ADDR_SETUP_NS = 70;
	localparam int T_DATA_SETUP_NS = 70;
	localparam int T_WR_LEN_NS = 60;
	localparam int T_RESET_NS = 90;

	// least time: round up, never below one cycle
	function automatic int cyc_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int SETUP_NS_MAX = (T_ADDR_SETUP_NS > T_DATA_SETUP_NS) ?
		T_ADDR_SETUP_NS : T_DATA_SETUP_NS;
	// chip select falls one cycle before the strobe, so its lead is covered
	localparam int BUS_NS_MAX = (SETUP_NS_MAX > T_CS_SETUP_NS) ?
		SETUP_NS_MAX : T_CS_SETUP_NS;
	localparam int STROBE_NS = (BUS_NS_MAX > T_WR_LEN_NS) ?
		BUS_NS_MAX : T_WR_LEN_NS;
	localparam int STROBE_CYC = cyc_min(STROBE_NS);
	localparam int CS_LEAD_CYC = cyc_min(T_CS_SETUP_NS);
	localparam int RESET_CYC = cyc_min(T_RESET_NS);
	localparam int CNT_W = 8;

	// data word layout
	localparam int DATA_W = 8;
	localparam int LVL_W = 7;
	localparam int THR_W = 3;
	localparam int DIR_BIT = 7;
	localparam int THR_LSB = 4;

	// controller register map (byte addresses)
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_CTRL = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_MIRROR = 4'hC;
	localparam int CMD_CHAN_BIT = 8;
	localparam int CMD_THR_BIT = 9;
	localparam int CTRL_RESET_BIT = 0;
	localparam int MIR_CH2_LSB = 16;
	localparam int MIR_THR_OFS = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SETUP = 2'b01,
		ST_STROBE = 2'b10,
		ST_HOLD = 2'b11
	} dmwp_state_t;
endpackage

// ============================================================
// pin write sequencer
module dmwp_seq #(
	parameter int STROBE_CYC = dmwp_pkg::STROBE_CYC,
	parameter int RESET_CYC = dmwp_pkg::RESET_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// requests
	input wire logic start,
	input wire logic [7:0] start_data,
	input wire logic start_chan,
	input wire logic start_thr,
	input wire logic reset_req,
	// device pins
	output logic [7:0] data_out,
	output logic chan_sel,
	output logic thr_sel,
	output logic cs_n,
	output logic wr_n,
	output logic dev_reset,
	// status
	output logic busy,
	output logic commit
);
	localparam int CW = dmwp_pkg::CNT_W;

	dmwp_pkg::dmwp_state_t state, next_state;
	logic [CW-1:0] cnt, next_cnt, rst_cnt, next_rst_cnt;
	logic [7:0] next_data_out;
	logic next_chan_sel, next_thr_sel, next_cs_n, next_wr_n;
	logic next_dev_reset, next_busy, next_commit;
	logic reset_pend, next_reset_pend;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_rst_cnt = rst_cnt;
		next_data_out = data_out;
		next_chan_sel = chan_sel;
		next_thr_sel = thr_sel;
		next_cs_n = cs_n;
		next_wr_n = wr_n;
		next_dev_reset = dev_reset;
		next_commit = 1'b0;
		// a request arriving as the pending one is taken still counts
		next_reset_pend = reset_pend | reset_req;
		if (dev_reset) begin
			// pins stay idle and no write is taken while held
			if (rst_cnt <= 8'h01) begin
				next_dev_reset = 1'b0;
			end
			next_rst_cnt = rst_cnt - 8'h01;
		end
		unique case (state)
			dmwp_pkg::ST_IDLE: begin
				if (dev_reset) begin
					next_state = dmwp_pkg::ST_IDLE;
				end else if (reset_pend) begin
					next_dev_reset = 1'b1;
					next_rst_cnt = CW'(RESET_CYC);
					next_reset_pend = reset_req;
				end else if (start) begin
					next_data_out = start_data;
					next_chan_sel = start_chan;
					next_thr_sel = start_thr;
					next_cs_n = 1'b0;
					next_state = dmwp_pkg::ST_SETUP;
				end
			end
			dmwp_pkg::ST_SETUP: begin
				next_wr_n = 1'b0;
				next_cnt = CW'(STROBE_CYC - 1);
				next_state = dmwp_pkg::ST_STROBE;
			end
			dmwp_pkg::ST_STROBE: begin
				if (cnt == '0) begin
					// rising strobe edge is the capture instant
					next_wr_n = 1'b1;
					next_commit = 1'b1;
					next_state = dmwp_pkg::ST_HOLD;
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			dmwp_pkg::ST_HOLD: begin
				next_cs_n = 1'b1;
				next_state = dmwp_pkg::ST_IDLE;
			end
		endcase
		next_busy = (next_state != dmwp_pkg::ST_IDLE) || next_dev_reset ||
			next_reset_pend;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= dmwp_pkg::ST_IDLE;
			cnt <= '0;
			rst_cnt <= CW'(RESET_CYC);
			data_out <= 8'h00;
			chan_sel <= 1'b0;
			thr_sel <= 1'b0;
			cs_n <= 1'b1;
			wr_n <= 1'b1;
			dev_reset <= 1'b1;
			busy <= 1'b1;
			commit <= 1'b0;
			reset_pend <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			rst_cnt <= next_rst_cnt;
			data_out <= next_data_out;
			chan_sel <= next_chan_sel;
			thr_sel <= next_thr_sel;
			cs_n <= next_cs_n;
			wr_n <= next_wr_n;
			dev_reset <= next_dev_reset;
			busy <= next_busy;
			commit <= next_commit;
			reset_pend <= next_reset_pend;
		end
	end

	// ============================================================
	// checks
	logic [CW-1:0] low_len, high_len;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			low_len <= '0;
			high_len <= '0;
		end else begin
			low_len <= wr_n ? '0 : low_len + 8'h01;
			high_len <= dev_reset ? high_len + 8'h01 : '0;
		end
	end

	a_cs_covers_wr: assert property (@(posedge clk) disable iff (rst)
		!wr_n |-> !cs_n) else $error("strobe low without chip select");
	a_rise_under_cs: assert property (@(posedge clk) disable iff (rst)
		$rose(wr_n) |-> !cs_n && commit)
		else $error("strobe rose outside a selected write");
	a_strobe_width: assert property (@(posedge clk) disable iff (rst)
		$rose(wr_n) |-> low_len == CW'(STROBE_CYC))
		else $error("strobe low width wrong");
	a_data_stable: assert property (@(posedge clk) disable iff (rst)
		!cs_n && $past(!cs_n) |-> $stable(data_out))
		else $error("data moved during a write");
	a_addr_stable: assert property (@(posedge clk) disable iff (rst)
		!cs_n && $past(!cs_n) |-> $stable({chan_sel, thr_sel}))
		else $error("address moved during a write");
	a_reset_blocks: assert property (@(posedge clk) disable iff (rst)
		dev_reset |-> cs_n && wr_n) else $error("write during reset");
	a_reset_width: assert property (@(posedge clk) disable iff (rst)
		$fell(dev_reset) |-> high_len == CW'(RESET_CYC))
		else $error("device reset too short");
	a_cs_lead: assert property (@(posedge clk) disable iff (rst)
		$fell(cs_n) |-> wr_n ##1 !wr_n)
		else $error("chip select not ahead of strobe");
endmodule
`default_nettype wire

//--- dmwp_dev_model.sv
// behavioural model of the two-channel level and decay-threshold device.
// assumes the host drives these pins directly; the device has no clock.
`timescale 1ns/1ps
`default_nettype none
module dmwp_dev_model (
	// host write port
	input wire logic [7:0] data_in,
	input wire logic chan_sel,
	input wire logic thr_sel,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic reset,
	// driver pins
	output logic dir_ch1,
	output logic dir_ch2,
	output logic fd_n_ch1,
	output logic fd_n_ch2,
	// observation for the bench
	output logic [6:0] lvl_ch1,
	output logic [6:0] lvl_ch2,
	output logic [2:0] thr_ch1,
	output logic [2:0] thr_ch2,
	output var int writes,
	output var int faults
);
	realtime t_cs, t_bus, t_wr;

	// ============================================================
	// host timing watch
	initial begin
		writes = 0;
		faults = 0;
	end
	always @(negedge cs_n) t_cs = $realtime;
	always @(data_in or chan_sel or thr_sel) t_bus = $realtime;
	always @(negedge wr_n) begin
		t_wr = $realtime;
		if (cs_n !== 1'h0)
			faults++;
	end

	// ============================================================
	// registers, comparator and decay flip-flops per channel
	// reset is level-tested so a strobe during reset stores nothing
	always @(posedge wr_n or posedge reset) begin
		if (reset) begin
			lvl_ch1 <= 7'h00;
			lvl_ch2 <= 7'h00;
			thr_ch1 <= 3'h0;
			thr_ch2 <= 3'h0;
			dir_ch1 <= 1'h0;
			dir_ch2 <= 1'h0;
			fd_n_ch1 <= 1'h0;
			fd_n_ch2 <= 1'h0;
		end else if (cs_n === 1'h0) begin
			writes++;
			if ($realtime - t_cs < dmwp_pkg::T_CS_SETUP_NS ||
				$realtime - t_bus < dmwp_pkg::T_DATA_SETUP_NS ||
				$realtime - t_wr < dmwp_pkg::T_WR_LEN_NS ||
				$isunknown(data_in))
				faults++;
			case ({thr_sel, chan_sel})
			2'h0: begin
				fd_n_ch1 <= !((data_in[6:0] < lvl_ch1) &&
					(data_in[6:4] < thr_ch1));
				dir_ch1 <= data_in[7];
				lvl_ch1 <= data_in[6:0];
			end
			2'h1: begin
				fd_n_ch2 <= !((data_in[6:0] < lvl_ch2) &&
					(data_in[6:4] < thr_ch2));
				dir_ch2 <= data_in[7];
				lvl_ch2 <= data_in[6:0];
			end
			2'h2: thr_ch1 <= data_in[6:4];
			default: thr_ch2 <= data_in[6:4];
			endcase
		end
	end
endmodule
`default_nettype wire

//--- test_dmwp_top.sv
// self-checking bench for the dmwp host controller over AXI4-Lite.
// assumes the design files and the device model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_dmwp_top;
	logic clk, rst, awv, wv, bre, arv, rre;
	logic [3:0] awa, ws, ara;
	logic [31:0] wd, word;
	logic [1:0] resp;
	wire awr, wrd, bv, arr, rv, csn, wrn, dres, chs, ths, d1, d2, f1, f2;
	wire [1:0] br, rr;
	wire [31:0] rd;
	wire [7:0] dq;
	wire [6:0] l1, l2;
	wire [2:0] t1, t2;
	int wcnt, faults, mismatches, total_checks, rst_len;
	logic [6:0] e_lvl [2];
	logic [2:0] e_thr [2];
	logic e_dir [2];
	logic e_fd [2];
	// {threshold select, channel, data}
	localparam logic [9:0] SEQ [12] = '{10'h250, 10'h0FF, 10'h050,
		10'h040, 10'h185, 10'h03F, 10'h03F, 10'h20F, 10'h010, 10'h3F0,
		10'h104, 10'h170};

	// ============================================================
	// clock, design and device
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	dmwp_top dut_u (.CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awa),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
		.S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
		.S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
		.S_AXI_RREADY(rre), .DATA_OUT(dq), .CHANNEL_SELECT(chs),
		.THRESHOLD_REGISTER_SELECT(ths), .CS_N(csn), .WR_N(wrn),
		.DEVICE_RESET(dres), .DIRECTION_OUT_CH1(d1),
		.DIRECTION_OUT_CH2(d2), .FAST_DECAY_N_CH1(f1),
		.FAST_DECAY_N_CH2(f2));
	dmwp_dev_model dev_u (.data_in(dq), .chan_sel(chs), .thr_sel(ths),
		.cs_n(csn), .wr_n(wrn), .reset(dres), .dir_ch1(d1),
		.dir_ch2(d2), .fd_n_ch1(f1), .fd_n_ch2(f2), .lvl_ch1(l1),
		.lvl_ch2(l2), .thr_ch1(t1), .thr_ch2(t2), .writes(wcnt),
		.faults(faults));
	always @(posedge clk)
		if (dres === 1'h1)
			rst_len <= rst_len + 1;

	// ============================================================
	// compares and bus tasks
	task automatic check_word(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t: word %h want %h", $time, got, exp);
		end
	endtask
	task automatic check_resp(input logic [1:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t: resp %h want %h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk);
		awa <= a;
		wd <= d;
		ws <= s;
		awv <= 1'h1;
		wv <= 1'h1;
		bre <= 1'h1;
		do begin
			@(posedge clk);
			if (awv && awr === 1'h1)
				awv <= 1'h0;
			if (wv && wrd === 1'h1)
				wv <= 1'h0;
		end while (bv !== 1'h1);
		resp = br;
		bre <= 1'h0;
	endtask
	task automatic axi_rd(input logic [3:0] a);
		@(posedge clk);
		ara <= a;
		arv <= 1'h1;
		rre <= 1'h1;
		do begin
			@(posedge clk);
			if (arv && arr === 1'h1)
				arv <= 1'h0;
		end while (rv !== 1'h1);
		word = rd;
		resp = rr;
		rre <= 1'h0;
	endtask
	// no fixed wait: the controller tells when the pins are quiet
	task automatic wait_idle();
		do
			axi_rd(dmwp_pkg::REG_STATUS);
		while (word[0] !== 1'h0);
	endtask
	task automatic clear_exp();
		for (int i = 0; i < 2; i++) begin
			e_lvl[i] = 7'h00;
			e_thr[i] = 3'h0;
			e_dir[i] = 1'h0;
			e_fd[i] = 1'h0;
		end
	endtask
	task automatic predict(input logic [9:0] c);
		int n;
		n = c[8];
		if (c[9])
			e_thr[n] = c[6:4];
		else begin
			e_fd[n] = !((c[6:0] < e_lvl[n]) && (c[6:4] < e_thr[n]));
			e_dir[n] = c[7];
			e_lvl[n] = c[6:0];
		end
	endtask
	task automatic check_state();
		check_word({12'h000, l2, l1, t2, t1},
			{12'h000, e_lvl[1], e_lvl[0], e_thr[1], e_thr[0]});
		check_word({28'h0, f2, f1, d2, d1},
			{28'h0, e_fd[1], e_fd[0], e_dir[1], e_dir[0]});
		axi_rd(dmwp_pkg::REG_STATUS);
		check_word(word, {26'h0, e_fd[1], e_fd[0], e_dir[1], e_dir[0],
			2'h0});
		axi_rd(dmwp_pkg::REG_MIRROR);
		check_word(word, {5'h00, e_thr[1], e_dir[1], e_lvl[1], 5'h00,
			e_thr[0], e_dir[0], e_lvl[0]});
	endtask
	task automatic cmd(input logic [9:0] c);
		axi_wr(dmwp_pkg::REG_CMD, {22'h0, c}, 4'h3);
		check_resp(resp, dmwp_pkg::RESP_OKAY);
		predict(c);
		wait_idle();
		check_state();
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ============================================================
	// tests
	initial begin
		#100000;
		mismatches++;
		give_verdict();
	end
	initial begin
		rst = 1'h1;
		{awv, wv, bre, arv, rre} = 5'h00;
		{awa, ws, ara} = 12'h000;
		wd = 32'h0;
		mismatches = 0;
		total_checks = 0;
		rst_len = 0;
		clear_exp();
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		axi_wr(dmwp_pkg::REG_CMD, 32'h0000007F, 4'h3);
		check_resp(resp, dmwp_pkg::RESP_SLVERR);
		wait_idle();
		check_state();
		axi_rd(4'h2);
		check_resp(resp, dmwp_pkg::RESP_DECERR);
		check_word(word, 32'h0);
		for (int i = 0; i < 12; i++)
			cmd(SEQ[i]);
		// a second order while the pins are busy must be refused
		axi_wr(dmwp_pkg::REG_CMD, 32'h00000011, 4'h3);
		predict(10'h011);
		axi_wr(dmwp_pkg::REG_CMD, 32'h00000122, 4'h3);
		check_resp(resp, dmwp_pkg::RESP_SLVERR);
		wait_idle();
		check_state();
		axi_wr(dmwp_pkg::REG_CMD, 32'h00000133, 4'h1);
		check_resp(resp, dmwp_pkg::RESP_OKAY);
		wait_idle();
		check_state();
		rst_len = 0;
		axi_wr(dmwp_pkg::REG_CTRL, 32'h00000001, 4'h1);
		check_resp(resp, dmwp_pkg::RESP_OKAY);
		axi_wr(dmwp_pkg::REG_CMD, 32'h00000055, 4'h3);
		check_resp(resp, dmwp_pkg::RESP_SLVERR);
		wait_idle();
		clear_exp();
		check_state();
		check_word(rst_len, dmwp_pkg::RESET_CYC);
		cmd(10'h19A);
		check_word(wcnt, 32'h0000000E);
		check_word(faults, 32'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
